// >>> core/sdcd_bank.sv
// state of one bank: idle or active with its open row
`timescale 1ns/100ps
module sdcd_bank (
	input  wire logic clk_i,
	input  wire logic reset_i,
	sdcd_bank_if.bank b
);
	typedef struct packed {
		logic        active;
		logic [12:0] row;
	} sdcd_bank_s;
	sdcd_bank_s q, d;

	always_comb begin
		d = q;
		if (b.open) begin
			d.active = 1'b1;
			d.row    = b.row;
		end else if (b.close) begin
			d.active = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign b.active   = q.active;
	assign b.open_row = q.row;
endmodule

// >>> core/sdcd_bank_if.sv
// per-bank open/close requests from the decoder to a bank tracker
`timescale 1ns/100ps
interface sdcd_bank_if;
	logic       open;
	logic       close;
	logic [12:0] row;
	logic       active;
	logic [12:0] open_row;
	modport dec  (output open, output close, output row, input active, input open_row);
	modport bank (input open, input close, input row, output active, output open_row);
endinterface

// >>> core/sdcd_decode.sv
// command decoder, bank state and power mode control of the sdram
`timescale 1ns/100ps
// What this block does
// - commands sampled only on rising clock edge
// - row open latches bank and 13-bit row
// - writes after open use only byte masks
// - read/write decode, 9-bit column, autoprecharge flag
// - open/mode need idle, access needs active
// - burst stop valid only during a burst
// - refresh with clock gate high, else self-refresh
// - clock gate judged now and previous cycle
// - clock gate fall during a burst, or while active with a non-nop command, enters suspend
// - suspend exits on clock gate rise
// - power-down on gate fall with nop/deselect
// - power-down during burst becomes suspend
// - power-down exits on gate rise with nop
// - precharge one bank or all by flag
// - mode register takes bank and address bits
// - byte mask blocks write, read one clock later
module sdcd_decode #(
	parameter int BURST_LEN_MAX = 512
) (
	input  wire logic                        clk_i,
	input  wire logic                        reset_i,
	input  wire logic                        chip_select_n_i,
	input  wire logic                        row_strobe_n_i,
	input  wire logic                        col_strobe_n_i,
	input  wire logic                        write_enable_n_i,
	input  wire logic                        clock_gate_i,
	input  wire logic [1:0]                  bank_select_i,
	input  wire logic [sdcd_pkg::ROW_W-1:0]  address_i,
	input  wire logic [sdcd_pkg::LANES-1:0]  byte_lane_mask_i,
	input  wire logic                        burst_running_i,
	output logic [sdcd_pkg::BANKS-1:0]       bank_active_o,
	output logic [sdcd_pkg::ROW_W-1:0]       open_row_o,
	output logic [1:0]                       access_bank_o,
	output logic [sdcd_pkg::COL_W-1:0]       column_o,
	output logic                             read_o,
	output logic                             write_o,
	output logic                             autoprecharge_flag_bit_o,
	output logic                             burst_stop_o,
	output logic                             auto_refresh_o,
	output logic                             mode_set_o,
	output logic [14:0]                      mode_code_o,
	output logic                             illegal_cmd_o,
	output logic [1:0]                       power_mode_o,
	output logic [sdcd_pkg::LANES-1:0]       write_lane_en_o,
	output logic [sdcd_pkg::LANES-1:0]       read_lane_en_o
);
	typedef struct packed {
		logic                       gate_prev;
		sdcd_pkg::sdcd_mode_e       mode;
		logic [1:0]                 bank;
		logic [sdcd_pkg::ROW_W-1:0] row;
		logic [sdcd_pkg::COL_W-1:0] col;
		logic                       rd;
		logic                       wr;
		logic                       ap;
		logic                       stop;
		logic                       refresh;
		logic                       mset;
		logic [14:0]                mcode;
		logic                       bad;
		logic [sdcd_pkg::LANES-1:0] wlane;
		logic [sdcd_pkg::LANES-1:0] mask_d1;
		logic [sdcd_pkg::LANES-1:0] mask_d2;
	} sdcd_state_s;

	sdcd_state_s q, d;
	sdcd_bank_if bif [sdcd_pkg::BANKS] ();
	logic [sdcd_pkg::BANKS-1:0]  act;
	logic [sdcd_pkg::ROW_W-1:0]  rows [sdcd_pkg::BANKS];
	logic [sdcd_pkg::BANKS-1:0]  open_v;
	logic [sdcd_pkg::BANKS-1:0]  close_v;
	sdcd_pkg::sdcd_cmd_e         cmd;
	logic                        sel_active;
	logic                        any_active;
	logic                        nop_like;
	logic                        cmd_ok;

	genvar g;
	generate
		for (g = 0; g < sdcd_pkg::BANKS; g++) begin : g_bank
			assign bif[g].open  = open_v[g];
			assign bif[g].close = close_v[g];
			assign bif[g].row   = address_i;
			assign act[g]       = bif[g].active;
			assign rows[g]      = bif[g].open_row;
			sdcd_bank u_bank (
				.clk_i   (clk_i),
				.reset_i (reset_i),
				.b       (bif[g])
			);
		end
	endgenerate

	// inputs are synchronous; all decoding is on the sampled edge
	assign cmd = sdcd_pkg::sdcd_cmd_e'({chip_select_n_i, row_strobe_n_i,
		col_strobe_n_i, write_enable_n_i});
	assign sel_active = act[bank_select_i];
	assign any_active = |act;
	// deselect ignores strobes; all-high strobes is a no-operation
	assign nop_like   = chip_select_n_i || (cmd == sdcd_pkg::SDCD_CMD_NOP);
	// commands only count in run mode with the gate high last cycle
	assign cmd_ok     = (q.mode == sdcd_pkg::SDCD_RUN) && q.gate_prev && !chip_select_n_i;

	always_comb begin
		d          = q;
		open_v     = '0;
		close_v    = '0;
		d.gate_prev = clock_gate_i;
		d.rd       = 1'b0;
		d.wr       = 1'b0;
		d.stop     = 1'b0;
		d.refresh  = 1'b0;
		d.mset     = 1'b0;
		d.bad      = 1'b0;
		d.mask_d1  = byte_lane_mask_i;
		d.mask_d2  = q.mask_d1;
		// write data blocked in the same cycle, no other masking
		d.wlane    = ~byte_lane_mask_i;

		case (q.mode)
			sdcd_pkg::SDCD_RUN: begin
				if (q.gate_prev && !clock_gate_i) begin
					// gate fall: suspend beats power-down while busy
					if (any_active && (burst_running_i || !nop_like)) begin
						d.mode = sdcd_pkg::SDCD_SUSPEND;
					end else if (burst_running_i) begin
						d.mode = sdcd_pkg::SDCD_SUSPEND;
					end else if (nop_like) begin
						d.mode = sdcd_pkg::SDCD_PDOWN;
					end
				end
				if (cmd_ok) begin
					case (cmd)
						sdcd_pkg::SDCD_CMD_ACT: begin
							if (!sel_active) begin
								open_v[bank_select_i] = 1'b1;
							end else begin
								d.bad = 1'b1;
							end
						end
						sdcd_pkg::SDCD_CMD_PRE: begin
							if (address_i[sdcd_pkg::AP_BIT]) begin
								close_v = '1;
							end else begin
								close_v[bank_select_i] = 1'b1;
							end
						end
						sdcd_pkg::SDCD_CMD_READ,
						sdcd_pkg::SDCD_CMD_WRITE: begin
							if (sel_active) begin
								d.rd   = (cmd == sdcd_pkg::SDCD_CMD_READ);
								d.wr   = (cmd == sdcd_pkg::SDCD_CMD_WRITE);
								d.bank = bank_select_i;
								d.col  = address_i[sdcd_pkg::COL_W-1:0];
								d.ap   = address_i[sdcd_pkg::AP_BIT];
								d.row  = rows[bank_select_i];
								// flag only: the burst logic outside closes the bank
							end else begin
								d.bad = 1'b1;
							end
						end
						sdcd_pkg::SDCD_CMD_MRS: begin
							if (!any_active) begin
								d.mset  = 1'b1;
								d.mcode = {bank_select_i, address_i};
							end else begin
								d.bad = 1'b1;
							end
						end
						sdcd_pkg::SDCD_CMD_STOP: begin
							if (burst_running_i) begin
								d.stop = 1'b1;
							end else begin
								d.bad = 1'b1;
							end
						end
						sdcd_pkg::SDCD_CMD_REF: begin
							if (any_active) begin
								d.bad = 1'b1;
							end else if (clock_gate_i) begin
								d.refresh = 1'b1;
							end else begin
								d.mode = sdcd_pkg::SDCD_SREF;
							end
						end
						default: begin
						end
					endcase
				end
			end
			sdcd_pkg::SDCD_SUSPEND: begin
				// command inputs ignored here; exit on rise alone
				if (!q.gate_prev && clock_gate_i) begin
					d.mode = sdcd_pkg::SDCD_RUN;
				end
			end
			sdcd_pkg::SDCD_PDOWN,
			sdcd_pkg::SDCD_SREF: begin
				if (!q.gate_prev && clock_gate_i && nop_like) begin
					d.mode = sdcd_pkg::SDCD_RUN;
				end
			end
			default: begin
				d.mode = sdcd_pkg::SDCD_RUN;
			end
		endcase
	end

	// bank state registers once per cycle; the struct holds the rest
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			q      <= '0;
			q.mode <= sdcd_pkg::SDCD_RUN;
		end else begin
			q <= d;
		end
	end

	// output stages, each a flip-flop
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			bank_active_o            <= sdcd_pkg::BANKS_IDLE_RST;
			open_row_o               <= '0;
			access_bank_o            <= '0;
			column_o                 <= '0;
			read_o                   <= 1'b0;
			write_o                  <= 1'b0;
			autoprecharge_flag_bit_o <= 1'b0;
			burst_stop_o             <= 1'b0;
			auto_refresh_o           <= 1'b0;
			mode_set_o               <= 1'b0;
			mode_code_o              <= '0;
			illegal_cmd_o            <= 1'b0;
			power_mode_o             <= 2'h0;
			write_lane_en_o          <= '0;
			read_lane_en_o           <= '0;
		end else begin
			bank_active_o            <= act;
			open_row_o               <= q.row;
			access_bank_o            <= q.bank;
			column_o                 <= q.col;
			read_o                   <= q.rd;
			write_o                  <= q.wr;
			autoprecharge_flag_bit_o <= q.ap;
			burst_stop_o             <= q.stop;
			auto_refresh_o           <= q.refresh;
			mode_set_o               <= q.mset;
			mode_code_o              <= q.mcode;
			illegal_cmd_o            <= q.bad;
			power_mode_o             <= q.mode;
			write_lane_en_o          <= q.wlane;
			// mask three clocks before the read lane enable, one clock more than for writes
			read_lane_en_o           <= ~q.mask_d2;
		end
	end
endmodule

// >>> core/sdcd_pkg.sv
// shared constants and types for the sdram command decoder
package sdcd_pkg;
	localparam int ROW_W   = 13;
	localparam int COL_W   = 9;
	localparam int BANKS   = 4;
	localparam int LANES   = 4;
	localparam int AP_BIT  = 10;
	localparam int DQM_LAT = 2;
	localparam logic [3:0] BANKS_IDLE_RST = 4'h0;

	// {cs_n, ras_n, cas_n, we_n}
	typedef enum logic [3:0] {
		SDCD_CMD_ACT   = 4'h3,
		SDCD_CMD_PRE   = 4'h2,
		SDCD_CMD_WRITE = 4'h4,
		SDCD_CMD_READ  = 4'h5,
		SDCD_CMD_MRS   = 4'h0,
		SDCD_CMD_NOP   = 4'h7,
		SDCD_CMD_STOP  = 4'h6,
		SDCD_CMD_REF   = 4'h1
	} sdcd_cmd_e;

	// gray along idle -> suspend/power-down/self-refresh
	typedef enum logic [1:0] {
		SDCD_RUN     = 2'h0,
		SDCD_SUSPEND = 2'h1,
		SDCD_PDOWN   = 2'h3,
		SDCD_SREF    = 2'h2
	} sdcd_mode_e;
endpackage

// >>> tb/sdcd_ctrl_model.sv
// memory controller model that places commands on the pins
`timescale 1ns/100ps
module sdcd_ctrl_model (
	input  wire logic  clk_i,
	output logic [3:0] cmd_o,
	output logic       gate_o,
	output logic [1:0] bank_o,
	output logic [12:0] addr_o
);
	localparam int GAP = 3;
	initial begin
		cmd_o = 4'hF;
		gate_o = 1'b0;
		bank_o = 2'h0;
		addr_o = 13'h0;
	end
	task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a,
			input logic g);
		@(negedge clk_i);
		cmd_o = c;
		gate_o = g;
		bank_o = b;
		addr_o = a;
		@(negedge clk_i);
		cmd_o = sdcd_pkg::SDCD_CMD_NOP;
		// idle lines must not keep the old value
		bank_o = ~b;
		addr_o = ~a;
		// open or close: allow row-to-column, row cycle and bank spacing
		if (c == sdcd_pkg::SDCD_CMD_ACT || c == sdcd_pkg::SDCD_CMD_PRE)
			repeat (GAP) @(negedge clk_i);
	endtask
endmodule

// >>> tb/sdcd_monitor.sv
// port assertions for the sdram command decoder
`timescale 1ns/100ps
module sdcd_monitor (
	input wire logic        clk_i,
	input wire logic        reset_i,
	input wire logic        chip_select_n_i,
	input wire logic        row_strobe_n_i,
	input wire logic        col_strobe_n_i,
	input wire logic        write_enable_n_i,
	input wire logic        clock_gate_i,
	input wire logic [1:0]  bank_select_i,
	input wire logic [12:0] address_i,
	input wire logic [3:0]  byte_lane_mask_i,
	input wire logic        burst_running_i,
	input wire logic [3:0]  bank_active_o,
	input wire logic [1:0]  access_bank_o,
	input wire logic [8:0]  column_o,
	input wire logic        read_o,
	input wire logic        write_o,
	input wire logic        autoprecharge_flag_bit_o,
	input wire logic        burst_stop_o,
	input wire logic        auto_refresh_o,
	input wire logic        mode_set_o,
	input wire logic [14:0] mode_code_o,
	input wire logic        illegal_cmd_o,
	input wire logic [1:0]  power_mode_o,
	input wire logic [3:0]  write_lane_en_o,
	input wire logic [3:0]  read_lane_en_o
);
	logic [1:0] up_q;
	logic [1:0] g_q;
	wire [3:0] cmd = {chip_select_n_i, row_strobe_n_i, col_strobe_n_i, write_enable_n_i};
	wire nop = chip_select_n_i || cmd == 4'h7;
	wire pulse = read_o || write_o || burst_stop_o || auto_refresh_o || mode_set_o || illegal_cmd_o;
	// conservative: mode output lags, so only judge long-settled run states
	wire run = up_q == 2'h3 && power_mode_o == 2'h0 && g_q == 2'h3;
	wire ok = run && clock_gate_i;
	wire fall = run && !clock_gate_i && nop;
	wire hit = bank_active_o[bank_select_i];
	always_ff @(posedge clk_i) begin
		up_q <= reset_i ? 2'h0 : up_q + {1'b0, up_q != 2'h3};
		g_q <= {g_q[0], clock_gate_i};
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	rd_col_a: assert property (
		ok && cmd == 4'h5 && hit |-> ##2 read_o && column_o == $past(address_i[8:0], 2)
		&& access_bank_o == $past(bank_select_i, 2))
		else $error("read pulse, column or bank wrong");
	wr_flag_a: assert property (
		ok && cmd == 4'h4 && hit |-> ##2 write_o && autoprecharge_flag_bit_o == $past(address_i[10], 2))
		else $error("write pulse or flag wrong");
	bad_access_a: assert property (
		ok && cmd[3:1] == 3'h2 && !hit |-> ##2 illegal_cmd_o && !read_o && !write_o)
		else $error("access to idle bank not refused");
	desel_quiet_a: assert property (nop |-> ##2 !pulse)
		else $error("pulse after deselect or nop");
	mode_set_a: assert property (
		ok && cmd == 4'h0 && bank_active_o == 4'h0 |-> ##2 mode_set_o
		&& mode_code_o == $past({bank_select_i, address_i}, 2)) else $error("mode code wrong");
	pd_entry_a: assert property (
		fall && bank_active_o == 4'h0 && !burst_running_i |-> ##2 power_mode_o == 2'h3)
		else $error("power-down not entered");
	sus_entry_a: assert property (
		fall && bank_active_o != 4'h0 && burst_running_i |-> ##2 power_mode_o == 2'h1)
		else $error("suspend not entered");
	wake_a: assert property (
		!g_q[0] && clock_gate_i && nop && power_mode_o != 2'h0 |-> ##2 power_mode_o == 2'h0)
		else $error("no wake on gate rise");
	lane_mask_a: assert property (ok |-> read_lane_en_o == ~$past(byte_lane_mask_i, 3))
		else $error("read lane enable wrong");
	wr_lane_a: assert property (
		up_q == 2'h3 |-> write_lane_en_o == ~$past(byte_lane_mask_i, 2))
		else $error("write lane enable wrong");
	cover property (ok && cmd == 4'h5 && hit);
	cover property (fall && burst_running_i);
	cover property (power_mode_o == 2'h2);
endmodule
bind sdcd_decode sdcd_monitor u_mon (.clk_i, .reset_i, .chip_select_n_i, .row_strobe_n_i,
	.col_strobe_n_i, .write_enable_n_i, .clock_gate_i, .bank_select_i, .address_i,
	.byte_lane_mask_i, .burst_running_i, .bank_active_o, .column_o, .read_o, .write_o,
	.autoprecharge_flag_bit_o, .burst_stop_o, .auto_refresh_o, .mode_set_o, .mode_code_o,
	.illegal_cmd_o, .power_mode_o, .read_lane_en_o, .access_bank_o, .write_lane_en_o);

// >>> tb/sdram_command_decode_tb.sv
// self-checking bench of the sdram command decoder
`timescale 1ns/100ps
module sdram_command_decode_tb;
	logic        clk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic [3:0]  mask = 4'h0;
	logic        burst = 1'b0;
	logic [19:0] rnd = 20'd91619;
	wire [3:0]   cmd;
	wire         gate;
	wire [1:0]   bank;
	wire [12:0]  addr;
	logic [3:0]  act;
	logic [1:0]  pm;
	logic [14:0] mcode;
	logic [14:0] mc;
	logic [8:0]  col;
	wire [5:0]   pv;
	logic [12:0] orow;
	logic [1:0]  abank;
	logic [8:0]  last_col = 9'h0;
	logic [14:0] exp_q[$];
	int          errors = 0;
	int          n_tests = 0;
	always #2.5 clk_i = ~clk_i;
	sdcd_ctrl_model u_ctl (.clk_i(clk_i), .cmd_o(cmd), .gate_o(gate), .bank_o(bank), .addr_o(addr));
	sdcd_decode u_dut (.clk_i(clk_i), .reset_i(reset_i), .chip_select_n_i(cmd[3]),
		.row_strobe_n_i(cmd[2]), .col_strobe_n_i(cmd[1]), .write_enable_n_i(cmd[0]),
		.clock_gate_i(gate), .bank_select_i(bank), .address_i(addr), .byte_lane_mask_i(mask),
		.burst_running_i(burst), .bank_active_o(act), .open_row_o(orow), .access_bank_o(abank),
		.column_o(col), .read_o(pv[5]), .write_o(pv[4]), .autoprecharge_flag_bit_o(),
		.burst_stop_o(pv[3]), .auto_refresh_o(pv[2]), .mode_set_o(pv[1]), .mode_code_o(mcode),
		.illegal_cmd_o(pv[0]), .power_mode_o(pm), .write_lane_en_o(), .read_lane_en_o());
	function automatic logic [19:0] lfsr(input logic [19:0] v);
		return {v[18:0], v[19] ^ v[16]};
	endfunction
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		n_tests++;
		if (s !== e) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic give_verdict;
		$display("tests %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// note the pulses due two edges on, then hand the command over
	task automatic go(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a,
			input logic g, input logic [5:0] p);
		if (p[5] || p[4])
			last_col = a[8:0];
		if (p != 6'h0)
			exp_q.push_back({p, last_col});
		u_ctl.issue(c, b, a, g);
	endtask
	task automatic settle;
		repeat (2) @(negedge clk_i);
	endtask
	always @(negedge clk_i) begin
		rnd = lfsr(rnd);
		mask <= rnd[3:0];
	end
	always @(posedge clk_i) begin
		#1;
		if (pv !== 6'h0)
			chk({1'b0, pv, col}, {1'b0, exp_q.size() ? exp_q.pop_front() : 15'h7FFF});
	end
	initial begin
		repeat (20) @(negedge clk_i);
		reset_i = 1'b0;
		go(sdcd_pkg::SDCD_CMD_NOP, 2'h0, 13'h0, 1'b1, 6'h00);
		go(sdcd_pkg::SDCD_CMD_READ, 2'h0, 13'h5, 1'b1, 6'h01);
		mc = rnd[14:0];
		go(sdcd_pkg::SDCD_CMD_ACT, 2'h1, mc[12:0], 1'b1, 6'h00);
		settle;
		chk({12'h0, act}, 16'h0002);
		go(sdcd_pkg::SDCD_CMD_READ, 2'h1, {4'h1, rnd[8:0]}, 1'b1, 6'h20);
		go(sdcd_pkg::SDCD_CMD_WRITE, 2'h1, {4'h2, rnd[8:0]}, 1'b1, 6'h10);
		go(sdcd_pkg::SDCD_CMD_ACT, 2'h1, 13'h0, 1'b1, 6'h01);
		chk({1'b0, abank, orow}, {1'b0, 2'h1, mc[12:0]});
		go(sdcd_pkg::SDCD_CMD_MRS, 2'h0, 13'h0, 1'b1, 6'h01);
		go(sdcd_pkg::SDCD_CMD_REF, 2'h0, 13'h0, 1'b1, 6'h01);
		go(sdcd_pkg::SDCD_CMD_STOP, 2'h0, 13'h0, 1'b1, 6'h01);
		burst = 1'b1;
		go(sdcd_pkg::SDCD_CMD_STOP, 2'h0, 13'h0, 1'b1, 6'h08);
		go(sdcd_pkg::SDCD_CMD_NOP, 2'h0, 13'h0, 1'b0, 6'h00);
		settle;
		chk({14'h0, pm}, 16'h0001);
		go(sdcd_pkg::SDCD_CMD_READ, 2'h1, 13'h3, 1'b0, 6'h00);
		go(sdcd_pkg::SDCD_CMD_STOP, 2'h0, 13'h0, 1'b1, 6'h00);
		settle;
		chk({14'h0, pm}, 16'h0000);
		burst = 1'b0;
		go(sdcd_pkg::SDCD_CMD_PRE, 2'h0, 13'h0400, 1'b1, 6'h00);
		settle;
		chk({12'h0, act}, 16'h0000);
		go(sdcd_pkg::SDCD_CMD_NOP, 2'h0, 13'h0, 1'b0, 6'h00);
		settle;
		chk({14'h0, pm}, 16'h0003);
		go(sdcd_pkg::SDCD_CMD_NOP, 2'h0, 13'h0, 1'b1, 6'h00);
		settle;
		chk({14'h0, pm}, 16'h0000);
		go(sdcd_pkg::SDCD_CMD_REF, 2'h0, 13'h0, 1'b1, 6'h04);
		mc = rnd[14:0];
		go(sdcd_pkg::SDCD_CMD_MRS, mc[14:13], mc[12:0], 1'b1, 6'h02);
		settle;
		chk({1'b0, mcode}, {1'b0, mc});
		go(sdcd_pkg::SDCD_CMD_REF, 2'h0, 13'h0, 1'b0, 6'h00);
		settle;
		chk({14'h0, pm}, 16'h0002);
		go(sdcd_pkg::SDCD_CMD_NOP, 2'h0, 13'h0, 1'b1, 6'h00);
		settle;
		chk({14'h0, pm}, 16'h0000);
		go(4'h8, 2'h0, 13'h0, 1'b1, 6'h00);
		repeat (4) @(negedge clk_i);
		chk(16'(exp_q.size()), 16'h0000);
		give_verdict;
	end
	initial begin
		#50000;
		errors++;
		give_verdict;
	end
endmodule
